// *** radio_mode_config_regs.sv ***
`timescale 1ns/100ps


module radio_mode_config_regs #(
    parameter logic [15:0] DEFAULT_LOCK_TIME = 16'h0000
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input rmc_pkg::rmc_cfg_req_s cfgReq,
    output logic [7:0] cfgRdData,
    input rmc_pkg::rmc_radio_s radio,
    input wire logic [15:0] customLockTime,
    output logic smartWakeEnable,
    output logic lowPowerRssiQualify,
    output logic ifFilterCalStart,
    output logic autoEnterRx,
    output logic autoEnterTx,
    output logic [15:0] synthLockTime,
    output logic [6:0] iqPhaseTrim,
    output logic [6:0] iqAmplitudeTrim,
    output logic preambleDetectOn,
    output logic [3:0] preambleErrorsAllowed,
    output logic preambleSettingAdvised,
    output logic syncWordLockAllowed,
    output logic lnaStrobePin,
    output logic lnaStrobeOe,
    output logic paStrobePin,
    output logic paStrobeOe
);

    // ==========================================================
    // State
    typedef struct packed {
        logic [7:0] phaseTrim;
        logic [7:0] amplitudeTrim;
        logic [7:0] options;
        logic [7:0] tolerance;
        logic [7:0] rdData;
        rmc_pkg::rmc_radio_state_e prevState;
        logic calStart;
        logic enterRx;
        logic enterTx;
        logic [15:0] lockTime;
        logic detectOn;
        logic [3:0] errAllowed;
        logic advised;
        logic syncLock;
    } rmc_regs_s;

    rmc_regs_s state_r;
    rmc_regs_s state_nxt;
    logic sleeping;
    logic inReceive;
    logic inTransmit;
    logic offToOn;

    // ==========================================================
    // Helpers
    function automatic logic isMapped(input logic [8:0] addr);
        isMapped = (addr == rmc_pkg::IQ_PHASE_TRIM_OFS) ||
            (addr == rmc_pkg::IQ_AMPLITUDE_TRIM_OFS) ||
            (addr == rmc_pkg::OPERATING_OPTIONS_OFS) ||
            (addr == rmc_pkg::PREAMBLE_ERROR_TOLERANCE_OFS);
    endfunction : isMapped

    function automatic logic optBit(input logic [7:0] opts, input int pos);
        optBit = opts[pos];
    endfunction : optBit

    function automatic logic inRange(input logic [3:0] val, input logic [3:0] lo,
        input logic [3:0] hi);
        inRange = (val >= lo) && (val <= hi);
    endfunction : inRange

    function automatic logic [3:0] errorsFor(input logic [3:0] setting);
        errorsFor = 4'(rmc_pkg::PREAMBLE_PAIRS - setting);
    endfunction : errorsFor

    function automatic logic turnaround(input logic pktMode, input logic doneEvent,
        input logic inState, input logic enable);
        turnaround = pktMode && doneEvent && inState && enable;
    endfunction : turnaround

    // ==========================================================
    // Next state
    always_comb begin
        logic [3:0] tol;
        tol = 4'h0;
        state_nxt = state_r;

        // Register writes
        if (cfgReq.wrEn && isMapped(cfgReq.addr)) begin
            unique case (cfgReq.addr)
                rmc_pkg::IQ_PHASE_TRIM_OFS: state_nxt.phaseTrim = cfgReq.wrData;
                rmc_pkg::IQ_AMPLITUDE_TRIM_OFS: state_nxt.amplitudeTrim = cfgReq.wrData;
                rmc_pkg::OPERATING_OPTIONS_OFS: state_nxt.options = cfgReq.wrData;
                rmc_pkg::PREAMBLE_ERROR_TOLERANCE_OFS: state_nxt.tolerance = cfgReq.wrData;
                default: state_nxt.options = state_r.options;
            endcase
        end

        // Register reads, one cycle latency, unmapped reads zero
        if (cfgReq.rdEn) begin
            state_nxt.rdData = 8'h00;
            if (cfgReq.addr == rmc_pkg::IQ_PHASE_TRIM_OFS) begin
                state_nxt.rdData = state_r.phaseTrim;
            end else if (cfgReq.addr == rmc_pkg::IQ_AMPLITUDE_TRIM_OFS) begin
                state_nxt.rdData = state_r.amplitudeTrim;
            end else if (cfgReq.addr == rmc_pkg::OPERATING_OPTIONS_OFS) begin
                state_nxt.rdData = state_r.options;
            end else if (cfgReq.addr == rmc_pkg::PREAMBLE_ERROR_TOLERANCE_OFS) begin
                state_nxt.rdData = state_r.tolerance;
            end
        end

        // Calibration pulse on off-to-on change
        state_nxt.prevState = radio.state;
        state_nxt.calStart = optBit(state_r.options, rmc_pkg::IF_FILTER_CAL_ENABLE_BIT) &&
            offToOn;

        // Automatic turnaround, same channel kept by the sequencer
        state_nxt.enterRx = turnaround(radio.packetMode, radio.txDone, inTransmit,
            optBit(state_r.options, rmc_pkg::AUTO_TX_THEN_RX_BIT));
        state_nxt.enterTx = turnaround(radio.packetMode, radio.rxValid, inReceive,
            optBit(state_r.options, rmc_pkg::AUTO_RX_THEN_TX_BIT));

        // Lock time selection
        state_nxt.lockTime = optBit(state_r.options, rmc_pkg::CUSTOM_LOCK_TIME_SELECT_BIT) ?
            customLockTime : DEFAULT_LOCK_TIME;

        // Preamble tolerance decode; reserved settings turn detection off
        tol = state_r.tolerance[rmc_pkg::TOLERANCE_MSB:0];
        state_nxt.detectOn = (tol != rmc_pkg::PREAMBLE_OFF) &&
            inRange(tol, rmc_pkg::PREAMBLE_OFF, rmc_pkg::PREAMBLE_PAIRS);
        state_nxt.errAllowed = state_nxt.detectOn ?
            errorsFor(tol) : 4'h0;
        state_nxt.advised = (tol == rmc_pkg::PREAMBLE_OFF) ||
            inRange(tol, rmc_pkg::PREAMBLE_LOWEST_ADVISED,
            rmc_pkg::PREAMBLE_PAIRS);

        // Sync word lock only with preamble detection off
        state_nxt.syncLock = (radio.freqCorrectionLockSetting == rmc_pkg::FREQ_CORR_LOCK) &&
            (tol == rmc_pkg::PREAMBLE_OFF);
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= '0;
            state_r.phaseTrim <= rmc_pkg::IQ_PHASE_TRIM_RST;
            state_r.amplitudeTrim <= rmc_pkg::IQ_AMPLITUDE_TRIM_RST;
            state_r.options <= rmc_pkg::OPERATING_OPTIONS_RST;
            state_r.tolerance <= rmc_pkg::PREAMBLE_ERROR_TOLERANCE_RST;
            state_r.prevState <= rmc_pkg::SLEEP_STATE;
            state_r.advised <= 1'b1;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ==========================================================
    // Outputs
    assign cfgRdData = state_r.rdData;
    assign smartWakeEnable = state_r.options[rmc_pkg::SMART_WAKE_ENABLE_BIT];
    assign lowPowerRssiQualify = state_r.options[rmc_pkg::LOW_POWER_RSSI_QUALIFY_BIT];
    assign ifFilterCalStart = state_r.calStart;
    assign autoEnterRx = state_r.enterRx;
    assign autoEnterTx = state_r.enterTx;
    assign synthLockTime = state_r.lockTime;
    assign iqPhaseTrim = state_r.phaseTrim[rmc_pkg::TRIM_MSB:0];
    assign iqAmplitudeTrim = state_r.amplitudeTrim[rmc_pkg::TRIM_MSB:0];
    assign preambleDetectOn = state_r.detectOn;
    assign preambleErrorsAllowed = state_r.errAllowed;
    assign preambleSettingAdvised = state_r.advised;
    assign syncWordLockAllowed = state_r.syncLock;

    // ==========================================================
    // Radio state decode
    assign inReceive = (radio.state == rmc_pkg::RECEIVE_STATE);
    assign inTransmit = (radio.state == rmc_pkg::TRANSMIT_STATE);
    assign offToOn = (state_r.prevState == rmc_pkg::OFF_STATE) &&
        (radio.state == rmc_pkg::ON_STATE);

    // ==========================================================
    // Strobe pins
    assign sleeping = (radio.state == rmc_pkg::SLEEP_STATE);

    rmc_strobe u_lna_strobe (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .strobeEnable(state_r.options[rmc_pkg::LNA_STROBE_ENABLE_BIT]),
        .activeState(inReceive),
        .sleeping(sleeping),
        .strobePin(lnaStrobePin),
        .strobeOe(lnaStrobeOe)
    );

    rmc_strobe u_pa_strobe (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .strobeEnable(state_r.options[rmc_pkg::PA_STROBE_ENABLE_BIT]),
        .activeState(inTransmit),
        .sleeping(sleeping),
        .strobePin(paStrobePin),
        .strobeOe(paStrobeOe)
    );

endmodule : radio_mode_config_regs

// *** rmc_pkg.sv ***
package rmc_pkg;

    // ==========================================================
    // Register offsets
    localparam logic [8:0] IQ_PHASE_TRIM_OFS = 9'h118;
    localparam logic [8:0] IQ_AMPLITUDE_TRIM_OFS = 9'h119;
    localparam logic [8:0] OPERATING_OPTIONS_OFS = 9'h11a;
    localparam logic [8:0] PREAMBLE_ERROR_TOLERANCE_OFS = 9'h11b;

    // ==========================================================
    // Reset values
    localparam logic [7:0] IQ_PHASE_TRIM_RST = 8'h00;
    localparam logic [7:0] IQ_AMPLITUDE_TRIM_RST = 8'h00;
    localparam logic [7:0] OPERATING_OPTIONS_RST = 8'h00;
    localparam logic [7:0] PREAMBLE_ERROR_TOLERANCE_RST = 8'h00;

    // ==========================================================
    // Field positions of operating_options
    localparam int SMART_WAKE_ENABLE_BIT = 7;
    localparam int IF_FILTER_CAL_ENABLE_BIT = 6;
    localparam int LOW_POWER_RSSI_QUALIFY_BIT = 5;
    localparam int AUTO_TX_THEN_RX_BIT = 4;
    localparam int AUTO_RX_THEN_TX_BIT = 3;
    localparam int CUSTOM_LOCK_TIME_SELECT_BIT = 2;
    localparam int LNA_STROBE_ENABLE_BIT = 1;
    localparam int PA_STROBE_ENABLE_BIT = 0;

    // ==========================================================
    // Trim and tolerance fields
    localparam int TRIM_MSB = 6;
    localparam int TOLERANCE_MSB = 3;
    localparam logic [3:0] PREAMBLE_OFF = 4'h0;
    localparam logic [3:0] PREAMBLE_PAIRS = 4'hc;
    localparam logic [3:0] PREAMBLE_LOWEST_ADVISED = 4'h8;

    // ==========================================================
    // Frequency correction lock setting
    localparam logic [1:0] FREQ_CORR_LOCK = 2'h3;

    // ==========================================================
    // Radio states
    typedef enum logic [2:0] {
        SLEEP_STATE,
        OFF_STATE,
        ON_STATE,
        RECEIVE_STATE,
        TRANSMIT_STATE
    } rmc_radio_state_e;

    // ==========================================================
    // Carriers
    typedef struct packed {
        logic [8:0] addr;
        logic wrEn;
        logic [7:0] wrData;
        logic rdEn;
    } rmc_cfg_req_s;

    typedef struct packed {
        rmc_radio_state_e state;
        logic packetMode;
        logic txDone;
        logic rxValid;
        logic [1:0] freqCorrectionLockSetting;
    } rmc_radio_s;

endpackage : rmc_pkg

// *** rmc_strobe.sv ***
`timescale 1ns/100ps

module rmc_strobe (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic strobeEnable,
    input wire logic activeState,
    input wire logic sleeping,
    output logic strobePin,
    output logic strobeOe
);

    // ==========================================================
    // State
    typedef struct packed {
        logic pin;
        logic oe;
    } rmc_strobe_s;

    rmc_strobe_s state_r;
    rmc_strobe_s state_nxt;

    // ==========================================================
    // Next state
    always_comb begin
        state_nxt = state_r;
        state_nxt.oe = strobeEnable && !sleeping;
        state_nxt.pin = strobeEnable && !sleeping && activeState;
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign strobePin = state_r.pin;
    assign strobeOe = state_r.oe;

endmodule : rmc_strobe

// *** rmc_assertions.sv ***
`timescale 1ns/100ps

module rmc_assertions (
    input wire logic ref_clk,
    input wire logic rst_n,
    input rmc_pkg::rmc_cfg_req_s cfgReq,
    input rmc_pkg::rmc_radio_s radio,
    input logic smartWakeEnable,
    input logic ifFilterCalStart,
    input logic autoEnterRx,
    input logic autoEnterTx,
    input logic [6:0] iqPhaseTrim,
    input logic preambleDetectOn,
    input logic [3:0] preambleErrorsAllowed,
    input logic lnaStrobePin,
    input logic lnaStrobeOe,
    input logic paStrobePin,
    input logic paStrobeOe
);
    // ==========================================================
    // Checks
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    logic opsWr;
    logic preWr;
    assign opsWr = cfgReq.wrEn && cfgReq.addr == rmc_pkg::OPERATING_OPTIONS_OFS;
    assign preWr = cfgReq.wrEn && cfgReq.addr == rmc_pkg::PREAMBLE_ERROR_TOLERANCE_OFS;
    a_wake_follows_write: assert property (
        opsWr |=> smartWakeEnable == $past(cfgReq.wrData[7])) else $error("wake bad");
    a_cal_power_up: assert property (
        ifFilterCalStart |-> $past(radio.state) == rmc_pkg::ON_STATE
        && $past(radio.state, 2) == rmc_pkg::OFF_STATE) else $error("cal bad");
    a_rx_after_tx: assert property (
        autoEnterRx |-> $past(radio.txDone && radio.packetMode
        && radio.state == rmc_pkg::TRANSMIT_STATE)) else $error("to rx bad");
    a_tx_after_rx: assert property (
        autoEnterTx |-> $past(radio.rxValid && radio.packetMode
        && radio.state == rmc_pkg::RECEIVE_STATE)) else $error("to tx bad");
    a_lna_pin_state: assert property (
        lnaStrobeOe |-> $past(radio.state) != rmc_pkg::SLEEP_STATE
        && lnaStrobePin == ($past(radio.state) == rmc_pkg::RECEIVE_STATE)) else $error("lna bad");
    a_pa_pin_state: assert property (
        paStrobeOe |-> $past(radio.state) != rmc_pkg::SLEEP_STATE
        && paStrobePin == ($past(radio.state) == rmc_pkg::TRANSMIT_STATE)) else $error("pa bad");
    a_preamble_errors: assert property (
        preWr && cfgReq.wrData[3:0] inside {[8:12]} ##1 !cfgReq.wrEn |=> preambleDetectOn
        && preambleErrorsAllowed == 4'hc - $past(cfgReq.wrData[3:0], 2)) else $error("pre bad");
    a_phase_trim_write: assert property (
        cfgReq.wrEn && cfgReq.addr == rmc_pkg::IQ_PHASE_TRIM_OFS
        |=> iqPhaseTrim == $past(cfgReq.wrData[6:0])) else $error("phase bad");
    c_cal: cover property (ifFilterCalStart);
    c_rx: cover property (autoEnterRx);
    c_tx: cover property (autoEnterTx);
endmodule : rmc_assertions

// *** rmc_host.sv ***
`timescale 1ns/100ps

module rmc_host (
    input wire logic ref_clk,
    input wire logic [7:0] cfgRdData,
    output rmc_pkg::rmc_cfg_req_s cfgReq
);
    initial cfgReq = '0;
    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        cfgReq <= '{a, 1'b1, d, 1'b0};
        @(posedge ref_clk);
        cfgReq <= '{~a, 1'b0, ~d, 1'b0};
    endtask : wr
    task automatic rd(input logic [8:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        cfgReq <= '{a, 1'b0, 8'h00, 1'b1};
        @(posedge ref_clk);
        cfgReq <= '{~a, 1'b0, 8'hff, 1'b0};
        #1 d = cfgRdData;
    endtask : rd
endmodule : rmc_host

// *** radio_mode_config_regs_test.sv ***
`timescale 1ns/100ps
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin err_count++; \
    $display("BAD %s exp %h got %h", n, e, s); end end

module radio_mode_config_regs_test;
    logic ref_clk = 0;
    logic rst_n = 0;
    rmc_pkg::rmc_cfg_req_s cfgReq;
    rmc_pkg::rmc_radio_s radio = '0;
    logic [15:0] custT = 16'h5a3c;
    logic [15:0] lockT;
    logic [7:0] rdData, q;
    logic [6:0] phT, amT;
    logic [3:0] errA;
    logic calS, rxS, txS, swE, rqE, detOn, adv, syncL, lnaP, lnaOe, paP, paOe;
    int err_count = 0;
    int total_checks = 0;
    int cyc = 0;
    localparam logic [8:0] OPS = rmc_pkg::OPERATING_OPTIONS_OFS;
    radio_mode_config_regs uut (.ref_clk(ref_clk), .rst_n(rst_n), .cfgReq(cfgReq),
        .cfgRdData(rdData), .radio(radio), .customLockTime(custT), .smartWakeEnable(swE),
        .lowPowerRssiQualify(rqE), .ifFilterCalStart(calS), .autoEnterRx(rxS),
        .autoEnterTx(txS), .synthLockTime(lockT), .iqPhaseTrim(phT), .iqAmplitudeTrim(amT),
        .preambleDetectOn(detOn), .preambleErrorsAllowed(errA), .preambleSettingAdvised(adv),
        .syncWordLockAllowed(syncL), .lnaStrobePin(lnaP), .lnaStrobeOe(lnaOe),
        .paStrobePin(paP), .paStrobeOe(paOe));
    rmc_host host (.ref_clk(ref_clk), .cfgRdData(rdData), .cfgReq(cfgReq));
    initial forever #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 2000) begin
            err_count++;
            test_done();
        end
    end
    task test_done;
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : test_done
    task t_regs;
        logic [7:0] v[4];
        v = '{8'ha5, 8'hb6, 8'hc7, 8'h09};
        for (int i = 0; i < 5; i++) begin
            host.rd(9'h118 + 9'(i), q);
            `CHK("rst", 8'h00, q)
        end
        for (int i = 0; i < 4; i++) host.wr(9'h118 + 9'(i), v[i]);
        host.wr(9'h117, 8'hff);
        for (int i = 0; i < 4; i++) begin
            host.rd(9'h118 + 9'(i), q);
            `CHK("rdback", v[i], q)
        end
        host.rd(9'h117, q);
        `CHK("unmapped", 8'h00, q)
        `CHK("phase", 7'h25, phT)
        `CHK("amp", 7'h36, amT)
    endtask : t_regs
    task t_opts;
        for (int i = 0; i < 8; i++) begin
            host.wr(OPS, 8'h01 << i);
            repeat (2) @(posedge ref_clk);
            #1;
            `CHK("wake", i == 7, swE)
            `CHK("rssi", i == 5, rqE)
            `CHK("lock", (i == 2) ? custT : 16'h0000, lockT)
        end
    endtask : t_opts
    task t_strobe(input logic [7:0] o);
        host.wr(OPS, o);
        for (int k = 0; k < 5; k++) begin
            @(posedge ref_clk);
            radio.state <= rmc_pkg::rmc_radio_state_e'(k);
            repeat (2) @(posedge ref_clk);
            #1;
            `CHK("lnaOe", o[1] && k != 0, lnaOe)
            `CHK("lnaPin", o[1] && k == 3, lnaP)
            `CHK("paOe", o[0] && k != 0, paOe)
            `CHK("paPin", o[0] && k == 4, paP)
        end
    endtask : t_strobe
    task watch(output logic [2:0] c, output logic [2:0] r, output logic [2:0] t);
        c = 3'h0;
        r = 3'h0;
        t = 3'h0;
        repeat (4) begin
            @(posedge ref_clk);
            radio.txDone <= 1'b0;
            radio.rxValid <= 1'b0;
            #1;
            c += calS;
            r += rxS;
            t += txS;
        end
    endtask : watch
    task t_cal(input logic [7:0] o, input int e);
        logic [2:0] c, r, t;
        host.wr(OPS, o);
        @(posedge ref_clk);
        radio.state <= rmc_pkg::OFF_STATE;
        @(posedge ref_clk);
        radio.state <= rmc_pkg::ON_STATE;
        watch(c, r, t);
        `CHK("cal", e, c)
        watch(c, r, t);
        `CHK("calHold", 0, c)
    endtask : t_cal
    task t_turn(input logic [7:0] o, input logic pm, input int er, input int et);
        logic [2:0] c, r, t;
        host.wr(OPS, o);
        @(posedge ref_clk);
        radio.packetMode <= pm;
        radio.state <= rmc_pkg::TRANSMIT_STATE;
        radio.txDone <= 1'b1;
        watch(c, r, t);
        `CHK("toRx", er, r)
        @(posedge ref_clk);
        radio.state <= rmc_pkg::RECEIVE_STATE;
        radio.rxValid <= 1'b1;
        watch(c, r, t);
        `CHK("toTx", et, t)
    endtask : t_turn
    task t_pre;
        logic on;
        @(posedge ref_clk);
        radio.freqCorrectionLockSetting <= rmc_pkg::FREQ_CORR_LOCK;
        for (int v = 0; v < 16; v++) begin
            host.wr(rmc_pkg::PREAMBLE_ERROR_TOLERANCE_OFS, 8'(v));
            repeat (2) @(posedge ref_clk);
            #1;
            on = v >= 1 && v <= 12;
            `CHK("detOn", on, detOn)
            `CHK("errs", on ? 4'(12 - v) : 4'h0, errA)
            `CHK("adv", v == 0 || (v >= 8 && v <= 12), adv)
            `CHK("sync", v == 0, syncL)
        end
        host.wr(rmc_pkg::PREAMBLE_ERROR_TOLERANCE_OFS, 8'h00);
        @(posedge ref_clk);
        radio.freqCorrectionLockSetting <= 2'h2;
        repeat (3) @(posedge ref_clk);
        #1;
        `CHK("syncOff", 1'b0, syncL)
    endtask : t_pre
    initial begin
        repeat (16) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_regs();
        t_opts();
        t_strobe(8'h03);
        t_strobe(8'h02);
        t_strobe(8'h00);
        t_cal(8'h40, 1);
        t_cal(8'h00, 0);
        t_turn(8'h18, 1'b1, 1, 1);
        t_turn(8'h10, 1'b1, 1, 0);
        t_turn(8'h08, 1'b1, 0, 1);
        t_turn(8'h18, 1'b0, 0, 0);
        t_pre();
        test_done();
    end
endmodule : radio_mode_config_regs_test

bind radio_mode_config_regs rmc_assertions chk (.ref_clk(ref_clk), .rst_n(rst_n),
    .cfgReq(cfgReq), .radio(radio), .smartWakeEnable(smartWakeEnable),
    .ifFilterCalStart(ifFilterCalStart), .autoEnterRx(autoEnterRx),
    .autoEnterTx(autoEnterTx), .iqPhaseTrim(iqPhaseTrim),
    .preambleDetectOn(preambleDetectOn), .preambleErrorsAllowed(preambleErrorsAllowed),
    .lnaStrobePin(lnaStrobePin), .lnaStrobeOe(lnaStrobeOe),
    .paStrobePin(paStrobePin), .paStrobeOe(paStrobeOe));
